// ### shared/ocmc_defs.svh
`ifndef OCMC_DEFS_SVH
`define OCMC_DEFS_SVH

// control-bus register offsets within the eight-word block at the tied base
`define OCMC_OFS_DBASE 3'h0
`define OCMC_OFS_DCTL 3'h1
`define OCMC_OFS_IBASE 3'h2
`define OCMC_OFS_ICTL 3'h3
`define OCMC_OFS_INIT 3'h4
`define OCMC_OFS_FILL 3'h5
`define OCMC_OFS_RATIO 3'h6

// decode enable is bit 0 in msb-first numbering, i.e. the top bit here
`define OCMC_DEC_EN_BIT 7

// reset values and start-up count
`define OCMC_RST_BYTE 8'h00
`define OCMC_RST_WORD 32'h0000_0000
`define OCMC_TIE_SETTLE 2'h2

// measured ratio limits, processor cycles per memory cycle
`define OCMC_RATIO_MIN 4'h1
`define OCMC_RATIO_MAX 4'h8

`endif

// ### shared/ocmc_pkg.sv
package ocmc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_INIT = 3'b100
  } ocmc_sys_st_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_READ = 3'b010,
    LK_DONE = 3'b100
  } ocmc_link_st_t;

  typedef enum logic [1:0] {
    OP_FETCH = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2
  } ocmc_op_t;

  // power-up tie inputs
  typedef struct packed {
    logic [7:0] data_base_tie_port;
    logic [7:0] data_control_tie_port;
    logic [7:0] instr_base_tie_port;
    logic [7:0] instr_control_tie_port;
    logic [6:0] ctrl_bus_base_tie;
  } ocmc_tie_t;

  // device control bus request, held by the master until acknowledged
  typedef struct packed {
    logic read;
    logic write;
    logic [9:0] addr;
    logic [31:0] wdata;
  } ocmc_ctrl_req_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } ocmc_fetch_req_t;

  typedef struct packed {
    logic en;
    logic [20:0] addr;
  } ocmc_ram_rd_t;

  typedef struct packed {
    logic en;
    logic [20:0] addr;
    logic lane;
    logic [31:0] data;
  } ocmc_ram_wr_t;

  typedef struct packed {
    ocmc_sys_st_t st;
    ocmc_tie_t tie_s1;
    ocmc_tie_t tie_s2;
    logic [1:0] settle;
    logic loaded;
    logic [7:0] data_space_base;
    logic [7:0] data_space_control;
    logic [7:0] instr_space_base;
    logic [7:0] instr_space_control;
    logic [21:0] instr_init_register;
    ocmc_op_t op;
    logic [20:0] xaddr;
    logic xlane;
    logic [31:0] xwdata;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic fetch_ready;
    logic fetch_valid;
    logic fetch_miss;
    logic [63:0] fetch_data;
    logic [4:0] data_gap;
    logic data_claim;
    logic data_miss;
    logic ctrl_ack;
    logic [31:0] ctrl_rd_data;
  } ocmc_sys_t;

  typedef struct packed {
    ocmc_link_st_t st;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    ocmc_ram_rd_t rd;
    ocmc_ram_wr_t wr;
    logic [63:0] rdata;
  } ocmc_link_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [3:0] cnt;
    logic [3:0] ratio;
  } ocmc_ratio_t;

endpackage : ocmc_pkg

// ### hdl/ocmc_ratio_det.sv
`include "ocmc_defs.svh"

module ocmc_ratio_det (
  // processor side
  input wire logic sys_clk,
  input wire logic rst_b,
  // memory side
  input wire logic instr_memory_clock,
  // measured processor cycles per memory cycle
  output logic [3:0] ratio
);

  logic link_tgl;
  ocmc_pkg::ocmc_ratio_t r;
  ocmc_pkg::ocmc_ratio_t next_r;

  // one toggle per rising memory clock edge, counted in the processor domain
  always_ff @(posedge instr_memory_clock or negedge rst_b) begin
    if (!rst_b) begin
      link_tgl <= 1'b0;
    end else begin
      link_tgl <= ~link_tgl;
    end
  end

  // sync jitter can shift one count; the clamp keeps the value in range
  always_comb begin
    next_r = r;
    next_r.s1 = link_tgl;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 != r.s3) begin
      next_r.cnt = 4'h0;
      // compare the count itself so a stalled memory clock cannot wrap it to zero
      if (r.cnt >= `OCMC_RATIO_MAX) begin
        next_r.ratio = `OCMC_RATIO_MAX;
      end else begin
        next_r.ratio = r.cnt + 4'h1;
      end
    end else if (r.cnt != 4'hF) begin
      next_r.cnt = r.cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.ratio <= `OCMC_RATIO_MIN;
    end else begin
      r <= next_r;
    end
  end

  assign ratio = r.ratio;

  chk_ratio_in_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ratio >= 4'h1 && ratio <= 4'h8)
    else $error("measured clock ratio out of range");

endmodule : ocmc_ratio_det

// ### hdl/ocmc_cfg.sv
`include "ocmc_defs.svh"

module ocmc_cfg #(
  parameter bit ENHANCED = 1'b1
) (
  // clocks and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic instr_memory_clock,
  // power-up tie inputs
  input wire ocmc_pkg::ocmc_tie_t tie_ports,
  // device control bus
  input wire ocmc_pkg::ocmc_ctrl_req_t ctrl_req,
  output logic ctrl_ack,
  output logic [31:0] ctrl_rd_data,
  // instruction fetch
  input wire ocmc_pkg::ocmc_fetch_req_t fetch_req,
  output logic fetch_ready,
  output logic fetch_valid,
  output logic fetch_miss,
  output logic [63:0] fetch_data,
  // data-side address decode
  input wire logic data_req,
  input wire logic [7:0] data_addr_hi,
  output logic data_claim,
  output logic data_miss,
  // instruction block ram, memory clock domain
  output ocmc_pkg::ocmc_ram_rd_t iram_rd,
  output ocmc_pkg::ocmc_ram_wr_t iram_wr,
  input wire logic [63:0] iram_rd_data
);

  ocmc_pkg::ocmc_sys_t s;
  ocmc_pkg::ocmc_sys_t next_s;
  ocmc_pkg::ocmc_link_t l;
  ocmc_pkg::ocmc_link_t next_l;
  logic [3:0] ratio;

  // window hit: top address byte equals base and decode is enabled
  function automatic logic ocmc_decode(input logic [7:0] addr_hi,
                                       input logic [7:0] base,
                                       input logic [7:0] ctl);
    ocmc_decode = ctl[`OCMC_DEC_EN_BIT] && (addr_hi == base);
  endfunction : ocmc_decode

  ocmc_ratio_det u_ratio (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .instr_memory_clock(instr_memory_clock),
    .ratio(ratio)
  );

  // processor-domain next state
  always_comb begin
    logic [2:0] ofs;
    logic take_ctrl;
    logic done;
    ofs = ctrl_req.addr[2:0];
    take_ctrl = 1'b0;
    done = 1'b0;
    next_s = s;
    next_s.tie_s1 = tie_ports;
    next_s.tie_s2 = s.tie_s1;
    next_s.ack_s1 = l.ack_tgl;
    next_s.ack_s2 = s.ack_s1;
    next_s.fetch_valid = 1'b0;
    next_s.fetch_miss = 1'b0;
    next_s.data_claim = 1'b0;
    next_s.data_miss = 1'b0;
    next_s.ctrl_ack = 1'b0;
    done = (s.ack_s2 != s.ack_seen);
    // ties are static, but still pass two flops; load once they settle
    if (!s.loaded) begin
      if (s.settle == `OCMC_TIE_SETTLE) begin
        next_s.loaded = 1'b1;
        next_s.data_space_base = s.tie_s2.data_base_tie_port;
        next_s.data_space_control = s.tie_s2.data_control_tie_port;
        next_s.instr_space_base = s.tie_s2.instr_base_tie_port;
        next_s.instr_space_control = s.tie_s2.instr_control_tie_port;
      end else begin
        next_s.settle = s.settle + 2'h1;
      end
    end else begin
      take_ctrl = (ctrl_req.read || ctrl_req.write) && !s.ctrl_ack &&
                  (ctrl_req.addr[9:3] == s.tie_s2.ctrl_bus_base_tie) &&
                  (ofs <= `OCMC_OFS_RATIO);
    end
    // plain registers answer at once, in any state
    if (take_ctrl && ofs != `OCMC_OFS_FILL) begin
      next_s.ctrl_ack = 1'b1;
      next_s.ctrl_rd_data = `OCMC_RST_WORD;
      case (ofs)
        `OCMC_OFS_DBASE: begin
          next_s.ctrl_rd_data[7:0] = s.data_space_base;
          if (ctrl_req.write) begin
            next_s.data_space_base = ctrl_req.wdata[7:0];
          end
        end
        `OCMC_OFS_DCTL: begin
          next_s.ctrl_rd_data[7:0] = s.data_space_control;
          if (ctrl_req.write) begin
            next_s.data_space_control = ctrl_req.wdata[7:0];
          end
        end
        `OCMC_OFS_IBASE: begin
          next_s.ctrl_rd_data[7:0] = s.instr_space_base;
          if (ctrl_req.write) begin
            next_s.instr_space_base = ctrl_req.wdata[7:0];
          end
        end
        `OCMC_OFS_ICTL: begin
          next_s.ctrl_rd_data[7:0] = s.instr_space_control;
          if (ctrl_req.write) begin
            next_s.instr_space_control = ctrl_req.wdata[7:0];
          end
        end
        `OCMC_OFS_INIT: begin
          next_s.ctrl_rd_data[21:0] = s.instr_init_register;
          if (ctrl_req.write) begin
            next_s.instr_init_register = ctrl_req.wdata[21:0];
          end
        end
        `OCMC_OFS_RATIO: begin
          next_s.ctrl_rd_data[3:0] = ratio;
        end
        default: begin
          next_s.ctrl_rd_data = `OCMC_RST_WORD;
        end
      endcase
    end
    // transfers to the memory domain, one outstanding at a time
    case (s.st)
      ocmc_pkg::ST_IDLE: begin
        if (fetch_req.req && s.loaded) begin
          if (ocmc_decode(fetch_req.addr[31:24], s.instr_space_base,
                          s.instr_space_control)) begin
            next_s.op = ocmc_pkg::OP_FETCH;
            next_s.xaddr = fetch_req.addr[23:3];
            next_s.req_tgl = ~s.req_tgl;
            next_s.st = ocmc_pkg::ST_FETCH;
          end else begin
            next_s.fetch_miss = 1'b1;
          end
        end else if (take_ctrl && ofs == `OCMC_OFS_FILL) begin
          next_s.xaddr = s.instr_init_register[21:1];
          next_s.xlane = s.instr_init_register[0];
          next_s.xwdata = ctrl_req.wdata;
          if (ctrl_req.write) begin
            next_s.op = ocmc_pkg::OP_WRITE;
            next_s.req_tgl = ~s.req_tgl;
            next_s.st = ocmc_pkg::ST_INIT;
          end else if (ENHANCED) begin
            next_s.op = ocmc_pkg::OP_READ;
            next_s.req_tgl = ~s.req_tgl;
            next_s.st = ocmc_pkg::ST_INIT;
          end else begin
            // base variant: the port is write-only, reads return zero
            next_s.ctrl_ack = 1'b1;
            next_s.ctrl_rd_data = `OCMC_RST_WORD;
          end
        end
      end
      ocmc_pkg::ST_FETCH: begin
        if (done) begin
          next_s.ack_seen = s.ack_s2;
          next_s.fetch_valid = 1'b1;
          next_s.fetch_data = l.rdata;
          next_s.st = ocmc_pkg::ST_IDLE;
        end
      end
      ocmc_pkg::ST_INIT: begin
        if (done) begin
          next_s.ack_seen = s.ack_s2;
          next_s.ctrl_ack = 1'b1;
          next_s.ctrl_rd_data = `OCMC_RST_WORD;
          if (s.op == ocmc_pkg::OP_READ) begin
            // msb-first: word 0 is the upper half of the doubleword
            next_s.ctrl_rd_data = s.xlane ? l.rdata[31:0] : l.rdata[63:32];
          end
          // auto-increment lets software stream a block through fill
          next_s.instr_init_register = s.instr_init_register + 22'h000001;
          next_s.st = ocmc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.st = ocmc_pkg::ST_IDLE;
      end
    endcase
    // data side shares no path with the fetch side, only the ratio
    if (data_req && s.loaded && s.data_gap == 5'h00) begin
      if (ocmc_decode(data_addr_hi, s.data_space_base,
                      s.data_space_control)) begin
        next_s.data_claim = 1'b1;
        next_s.data_gap = {ratio, 1'b0} - 5'h01;
      end else begin
        next_s.data_miss = 1'b1;
      end
    end else if (s.data_gap != 5'h00) begin
      next_s.data_gap = s.data_gap - 5'h01;
    end
    next_s.fetch_ready = s.loaded && (next_s.st == ocmc_pkg::ST_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.st <= ocmc_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // memory-domain next state; payload from the processor side is held
  // stable until the acknowledge toggle returns, so it is read directly
  always_comb begin
    next_l = l;
    next_l.req_s1 = s.req_tgl;
    next_l.req_s2 = l.req_s1;
    next_l.rd.en = 1'b0;
    next_l.wr.en = 1'b0;
    case (l.st)
      ocmc_pkg::LK_IDLE: begin
        if (l.req_s2 != l.req_seen) begin
          next_l.req_seen = l.req_s2;
          if (s.op == ocmc_pkg::OP_WRITE) begin
            next_l.wr.en = 1'b1;
            next_l.wr.addr = s.xaddr;
            next_l.wr.lane = s.xlane;
            next_l.wr.data = s.xwdata;
            next_l.ack_tgl = ~l.ack_tgl;
          end else begin
            next_l.rd.en = 1'b1;
            next_l.rd.addr = s.xaddr;
            next_l.st = ocmc_pkg::LK_READ;
          end
        end
      end
      ocmc_pkg::LK_READ: begin
        next_l.st = ocmc_pkg::LK_DONE;
      end
      ocmc_pkg::LK_DONE: begin
        next_l.rdata = iram_rd_data;
        next_l.ack_tgl = ~l.ack_tgl;
        next_l.st = ocmc_pkg::LK_IDLE;
      end
      default: begin
        next_l.st = ocmc_pkg::LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge instr_memory_clock or negedge rst_b) begin
    if (!rst_b) begin
      l <= '0;
      l.st <= ocmc_pkg::LK_IDLE;
    end else begin
      l <= next_l;
    end
  end

  // outputs straight from flops
  assign ctrl_ack = s.ctrl_ack;
  assign ctrl_rd_data = s.ctrl_rd_data;
  assign fetch_ready = s.fetch_ready;
  assign fetch_valid = s.fetch_valid;
  assign fetch_miss = s.fetch_miss;
  assign fetch_data = s.fetch_data;
  assign data_claim = s.data_claim;
  assign data_miss = s.data_miss;
  assign iram_rd = l.rd;
  assign iram_wr = l.wr;

  chk_tie_power_up: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(s.loaded) |-> s.instr_space_base == $past(s.tie_s2.instr_base_tie_port) &&
                        s.data_space_control == $past(s.tie_s2.data_control_tie_port))
    else $error("registers not loaded from tie inputs");

  chk_base_write_takes: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_ack && !$past(s.ctrl_ack) && $past(ctrl_req.write) &&
    $past(ctrl_req.addr) == {s.tie_s2.ctrl_bus_base_tie, `OCMC_OFS_DBASE}
    |-> s.data_space_base == $past(ctrl_req.wdata[7:0]))
    else $error("data base write not stored");

  chk_fetch_decode_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fetch_ready && fetch_req.req && !s.instr_space_control[`OCMC_DEC_EN_BIT]
    |=> fetch_miss && !fetch_valid && s.st == ocmc_pkg::ST_IDLE)
    else $error("fetch claimed with decode disabled");

  chk_fetch_completes: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(s.st == ocmc_pkg::ST_FETCH) |-> ##[4:40] fetch_valid)
    else $error("fetch not answered in time");

  chk_data_pacing: assert property (@(posedge sys_clk) disable iff (!rst_b)
    data_claim |=> !data_claim ##1 (ratio == 4'h1 || !data_claim) ##1
                   (ratio == 4'h1 || !data_claim))
    else $error("data accesses closer than two memory cycles");

  chk_data_window: assert property (@(posedge sys_clk) disable iff (!rst_b)
    data_claim |-> $past(data_addr_hi) == $past(s.data_space_base) &&
                   $past(s.data_space_control[`OCMC_DEC_EN_BIT]))
    else $error("data claim outside its window");

  chk_base_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ENHANCED && s.st == ocmc_pkg::ST_INIT |-> s.op == ocmc_pkg::OP_WRITE)
    else $error("read through fill in base variant");

  chk_ram_read_single: assert property (@(posedge instr_memory_clock)
    disable iff (!rst_b)
    iram_rd.en |=> !iram_rd.en ##1 !iram_rd.en)
    else $error("memory read issued back to back");

  chk_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_ack |=> !ctrl_ack)
    else $error("control acknowledge longer than a cycle");

endmodule : ocmc_cfg

// ### bench/ocmc_ram_model.sv
module ocmc_ram_model (
  // memory clock and reset
  input wire logic instr_memory_clock,
  input wire logic rst_b,
  // ram ports from the controller
  input wire ocmc_pkg::ocmc_ram_rd_t iram_rd,
  input wire ocmc_pkg::ocmc_ram_wr_t iram_wr,
  output logic [63:0] iram_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [63:0] mem [0:63];

  // contents present from configuration, before any fetch
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {32'hA5A5_0000 | 32'(i), 32'h5A5A_0000 | 32'(i)};
    end
  end

  // one-cycle latency; the word is not held past its slot, so a late sample shows garbage
  always @(posedge instr_memory_clock or negedge rst_b) begin
    if (!rst_b) begin
      iram_rd_data <= 64'h0;
    end else if (iram_rd.en) begin
      iram_rd_data <= mem[iram_rd.addr[5:0]];
    end else begin
      iram_rd_data <= ~iram_rd_data;
    end
  end

  // 32-bit writes, lane 0 is the upper word
  always @(posedge instr_memory_clock) begin
    if (iram_wr.en && !iram_wr.lane) begin
      mem[iram_wr.addr[5:0]][63:32] <= iram_wr.data;
    end else if (iram_wr.en) begin
      mem[iram_wr.addr[5:0]][31:0] <= iram_wr.data;
    end
  end
endmodule : ocmc_ram_model

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk;
  logic rst_b;
  logic instr_memory_clock;
  ocmc_pkg::ocmc_tie_t tie_ports;
  ocmc_pkg::ocmc_ctrl_req_t ctrl_req;
  ocmc_pkg::ocmc_fetch_req_t fetch_req;
  ocmc_pkg::ocmc_ram_rd_t iram_rd;
  ocmc_pkg::ocmc_ram_wr_t iram_wr;
  logic ctrl_ack;
  logic fetch_ready;
  logic fetch_valid;
  logic fetch_miss;
  logic data_req;
  logic data_claim;
  logic data_miss;
  logic [7:0] data_addr_hi;
  logic [31:0] ctrl_rd_data;
  logic [31:0] rd;
  logic [63:0] fetch_data;
  logic [63:0] iram_rd_data;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  // processor cycles per memory cycle as the two clock generators set it
  localparam int MEM_RATIO = 3;

  ocmc_cfg #(.ENHANCED(1'b1)) ocmc_cfg_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .instr_memory_clock(instr_memory_clock),
    .tie_ports(tie_ports), .ctrl_req(ctrl_req), .ctrl_ack(ctrl_ack),
    .ctrl_rd_data(ctrl_rd_data), .fetch_req(fetch_req), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_miss(fetch_miss), .fetch_data(fetch_data),
    .data_req(data_req), .data_addr_hi(data_addr_hi), .data_claim(data_claim),
    .data_miss(data_miss), .iram_rd(iram_rd), .iram_wr(iram_wr), .iram_rd_data(iram_rd_data)
  );

  ocmc_ram_model ocmc_ram_model_i (
    .instr_memory_clock(instr_memory_clock), .rst_b(rst_b),
    .iram_rd(iram_rd), .iram_wr(iram_wr), .iram_rd_data(iram_rd_data)
  );

  // processor clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // memory clock at 3:1, phase offset so edges never line up
  initial begin
    instr_memory_clock = 1'b0;
    #7;
    forever #15 instr_memory_clock = ~instr_memory_clock;
  end

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one control-bus access, held until the edge that samples ack high
  task automatic ctrl(input logic wr, input logic [2:0] ofs, input logic [31:0] wd,
                      output logic acked);
    @(posedge sys_clk);
    #1;
    ctrl_req = '{read: !wr, write: wr, addr: {tie_ports.ctrl_bus_base_tie, ofs}, wdata: wd};
    for (int i = 0; i < 60 && ctrl_ack !== 1'b1; i++) @(posedge sys_clk);
    rd = ctrl_rd_data;
    acked = (ctrl_ack === 1'b1);
    #1;
    ctrl_req = '0;
  endtask : ctrl

  task automatic reg_wr(input logic [2:0] ofs, input logic [31:0] wd);
    logic ok;
    ctrl(1'b1, ofs, wd, ok);
    check("write ack", 64'(ok), 64'h1);
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] ofs, input logic [31:0] exp);
    logic ok;
    ctrl(1'b0, ofs, 32'h0, ok);
    check("read ack", 64'(ok), 64'h1);
    check("read data", 64'(rd), 64'(exp));
  endtask : reg_rd

  // one fetch: wait for idle, present the address for the taking edge only
  task automatic fetch(input logic [31:0] addr, input logic hit, input logic [63:0] exp);
    @(posedge sys_clk);
    for (int i = 0; i < 60 && fetch_ready !== 1'b1; i++) @(posedge sys_clk);
    #1;
    fetch_req = '{req: 1'b1, addr: addr};
    @(posedge sys_clk);
    #1;
    fetch_req.req = 1'b0;
    // a taken hit keeps the port busy, a miss leaves it idle
    check("fetch ready", 64'(fetch_ready), 64'(!hit));
    for (int i = 0; i < 60 && fetch_valid !== 1'b1 && fetch_miss !== 1'b1; i++) begin
      @(posedge sys_clk);
    end
    check("fetch valid", 64'(fetch_valid), 64'(hit));
    check("fetch miss", 64'(fetch_miss), 64'(!hit));
    if (hit) begin
      check("fetch data", fetch_data, exp);
    end
  endtask : fetch

  // data-side decode, request held until claim or miss
  task automatic data_acc(input logic [7:0] hi, input logic hit);
    @(posedge sys_clk);
    #1;
    data_req = 1'b1;
    data_addr_hi = hi;
    for (int i = 0; i < 60 && data_claim !== 1'b1 && data_miss !== 1'b1; i++) begin
      @(posedge sys_clk);
    end
    check("data claim", 64'(data_claim), 64'(hit));
    check("data miss", 64'(data_miss), 64'(!hit));
    #1;
    data_req = 1'b0;
  endtask : data_acc

  // main sequence
  initial begin
    logic ok;
    logic [3:0] r;
    int gap;
    rst_b = 1'b0;
    tie_ports = '{data_base_tie_port: 8'h10, data_control_tie_port: 8'h80,
                  instr_base_tie_port: 8'h20, instr_control_tie_port: 8'h80,
                  ctrl_bus_base_tie: 7'h05};
    ctrl_req = '0;
    fetch_req = '0;
    data_req = 1'b0;
    data_addr_hi = 8'h00;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 40 && fetch_ready !== 1'b1; i++) @(posedge sys_clk);
    // power-up values come from the ties
    reg_rd(3'h0, 32'h0000_0010);
    reg_rd(3'h1, 32'h0000_0080);
    reg_rd(3'h2, 32'h0000_0020);
    reg_rd(3'h3, 32'h0000_0080);
    fetch(32'h2000_0018, 1'b1, {32'hA5A5_0003, 32'h5A5A_0003});
    fetch(32'h1000_0018, 1'b0, 64'h0);
    data_acc(8'h10, 1'b1);
    // both windows moved onto one shared base
    reg_wr(3'h0, 32'h0000_0030);
    reg_wr(3'h2, 32'h0000_0030);
    reg_rd(3'h0, 32'h0000_0030);
    reg_rd(3'h2, 32'h0000_0030);
    fetch(32'h3000_0020, 1'b1, {32'hA5A5_0004, 32'h5A5A_0004});
    data_acc(8'h30, 1'b1);
    data_acc(8'h20, 1'b0);
    // offset 7 belongs to nobody and stays unanswered
    ctrl(1'b0, 3'h7, 32'h0, ok);
    check("offset 7 ack", 64'(ok), 64'h0);
    // fill both words of doubleword 5, pointer advances per access
    reg_wr(3'h4, 32'h0000_000A);
    reg_wr(3'h5, 32'hCAFE_0001);
    reg_wr(3'h5, 32'h0BAD_0002);
    reg_rd(3'h4, 32'h0000_000C);
    fetch(32'h3000_0028, 1'b1, {32'hCAFE_0001, 32'h0BAD_0002});
    reg_wr(3'h4, 32'h0000_000B);
    reg_rd(3'h5, 32'h0BAD_0002);
    // measured ratio, the generators' ratio give or take one
    ctrl(1'b0, 3'h6, 32'h0, ok);
    check("ratio ack", 64'(ok), 64'h1);
    r = rd[3:0];
    check("ratio in range", 64'(r >= MEM_RATIO - 1 && r <= MEM_RATIO + 1), 64'h1);
    // held request: second claim spaced by two memory cycles
    @(posedge sys_clk);
    #1;
    data_req = 1'b1;
    data_addr_hi = 8'h30;
    for (int i = 0; i < 60 && data_claim !== 1'b1; i++) @(posedge sys_clk);
    gap = 0;
    do begin
      @(posedge sys_clk);
      gap++;
    end while (data_claim !== 1'b1 && gap < 60);
    #1;
    data_req = 1'b0;
    // spacing follows the measured ratio; the check holds it to the clocks the bench makes
    check("claim spacing",
          64'(gap >= 2 * MEM_RATIO && gap <= 2 * MEM_RATIO + 1), 64'h1);
    // both sides at once, neither waits on the other
    fork
      fetch(32'h3000_0018, 1'b1, {32'hA5A5_0003, 32'h5A5A_0003});
      data_acc(8'h30, 1'b1);
    join
    // decode switched off, nothing is claimed
    reg_wr(3'h3, 32'h0000_0000);
    fetch(32'h3000_0018, 1'b0, 64'h0);
    reg_wr(3'h1, 32'h0000_0000);
    data_acc(8'h30, 1'b0);
    report_and_stop();
  end
endmodule : tb
